// file: src/csbp_top.sv
/*
  Clocked serial port with an eight-word buffer, Avalon-MM register slave.
  Assumes serial pins and external shift clock are asynchronous to clk_sys_in.
*/
`timescale 1ns/10ps
module csbp_top (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic [csbp_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  input  wire logic [31:0]                 avs_writedata_in,
  output logic      [31:0]                 avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic                        shift_clk_in,
  output logic                             shift_clk_out,
  output logic                             shift_clk_oe_out,
  input  wire logic                        ser_data_in,
  output logic                             ser_data_out,
  output logic                             serial_burst_interrupt_out
);
  import csbp_pkg::*;

  // ***********************************************
  // Register bus slave
  // ***********************************************
  logic        ack_r;
  logic [31:0] rdata_r;
  csbp_ctrl_s  ctl_r;
  csbp_wctl_s  wctl_r;
  logic [7:0]  data_buffer_bytes_r [BUF_WORDS];

  wire acc     = avs_read_in | avs_write_in;
  wire wr_go   = avs_write_in & ack_r & avs_byteenable_in[0];
  wire rd_go   = avs_read_in & ack_r;
  wire hit_c1  = avs_address_in == IDX_PRIMARY_CTRL;
  wire hit_c2  = avs_address_in == IDX_WORD_CTRL;
  wire hit_st  = avs_address_in == IDX_STATUS;
  wire hit_buf = avs_address_in[12:3] == IDX_BUF_BASE[12:3];
  wire [2:0] buf_sel = avs_address_in[2:0];
  wire buf_wr  = wr_go & hit_buf;
  wire buf_rd  = rd_go & hit_buf;

  // One wait cycle per access; read data captured in the first cycle
  assign avs_waitrequest_out = acc & ~ack_r;
  assign avs_readdata_out    = rdata_r;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc & ~ack_r;
    end
  end

  // ***********************************************
  // Mode decode and serial pin sampling
  // ***********************************************
  csbp_state_e st_r;
  logic        sck_s1_r, sck_s2_r, sck_s3_r;
  logic        si_s1_r, si_s2_r;
  logic        sck_r, so_r, fell_r, irq_r, svc_r, unread_r, dummy_r;
  logic [2:0]  idx_r, bit_cnt_r;
  logic [7:0]  tx_sh_r, rx_sh_r;
  logic [6:0]  gap_cnt_r;
  logic        tick;

  wire [2:0] md      = ctl_r.mode;
  wire mode_tx       = (md == MODE_TX8) | (md == MODE_TX4) | (md == MODE_TXRX8);
  wire mode_rx       = (md == MODE_RX8) | (md == MODE_RX4) | (md == MODE_TXRX8);
  wire four          = (md == MODE_TX4) | (md == MODE_RX4);
  wire ext_clk       = ctl_r.clksel == CLK_EXT;
  wire clk_ok        = ext_clk | (ctl_r.clksel <= CLK_INT_MAX);
  wire active        = st_r != ST_IDLE;
  wire shifting      = st_r == ST_SHIFT;
  wire [2:0] last_bit = four ? 3'h3 : 3'h7;

  // Two flops before any logic looks at the pins
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= 3'h7;
      {si_s1_r, si_s2_r}             <= 2'h3;
    end else begin
      {sck_s1_r, sck_s2_r, sck_s3_r} <= {shift_clk_in, sck_s1_r, sck_s2_r};
      {si_s1_r, si_s2_r}             <= {ser_data_in, si_s1_r};
    end
  end

  // Internal divider runs only while the clock may toggle or a gap is timed
  csbp_div u_div (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .run_in     (~ext_clk & ((st_r == ST_SHIFT) | (st_r == ST_GAP))),
    .sel_in     (ctl_r.clksel),
    .tick_out   (tick)
  );

  // ***********************************************
  // Shift edges and word bookkeeping
  // ***********************************************
  wire fall_evt = ext_clk ? (sck_s3_r & ~sck_s2_r) : (tick & sck_r);
  wire rise_evt = ext_clk ? (~sck_s3_r & sck_s2_r) : (tick & ~sck_r);
  wire sh_fall  = shifting & fall_evt;
  wire sh_rise  = shifting & rise_evt & fell_r;
  wire word_end = sh_rise & (bit_cnt_r == last_bit);
  wire last_word = idx_r == wctl_r.count;
  wire [2:0] idx_nxt = last_word ? 3'h0 : idx_r + 3'h1;
  wire [7:0] rx_next = {si_s2_r, rx_sh_r[7:1]};
  wire [7:0] rx_word = four ? {4'h0, rx_next[7:4]} : rx_next;

  // Servicing: writes release transmit modes, reads release receive-only
  wire svc_evt  = mode_tx ? buf_wr : buf_rd;
  wire svc_done = svc_r | svc_evt;
  wire cancel   = ext_clk & mode_rx & ~mode_tx & unread_r;
  wire end_now  = ~ctl_r.start | cancel | dummy_r;
  wire go_wait  = ~ext_clk & last_word & ~svc_done;
  wire [2:0] mul = 3'((4'h1 << wctl_r.wait_code) - 4'h1);
  wire [6:0] gap_len = four ? {1'b0, mul, 3'h0} : {mul, 4'h0};
  wire go_gap   = ~ext_clk & (wctl_r.wait_code != 2'h0);
  wire start_go = ~active & ctl_r.start & ~ctl_r.abort & clk_ok & (mode_tx | mode_rx);
  wire store_rx = word_end & mode_rx & ~cancel;
  wire irq_evt  = word_end & last_word & ~cancel;

  // ***********************************************
  // Control registers
  // ***********************************************
  // Write-only: software writes whole bytes, reads return zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctl_r  <= CTRL_RST;
      wctl_r <= WCTL_RST;
    end else begin
      if (wr_go && hit_c1) begin
        ctl_r <= avs_writedata_in[7:0];
      end else if (ctl_r.abort) begin
        ctl_r.abort <= 1'b0;
      end
      if (wr_go && hit_c2) begin
        wctl_r <= avs_writedata_in[7:0];
      end
    end
  end

  // Read mux; control registers and unmapped words read zero
  wire [7:0] stat_byte = {active, shifting, 6'h0};
  wire [7:0] rd_byte   = hit_st ? stat_byte :
                         hit_buf ? data_buffer_bytes_r[buf_sel] : 8'h00;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_r <= 32'h0;
    end else if (acc && !ack_r) begin
      rdata_r <= {24'h0, rd_byte};
    end
  end

  // Buffer: the shifter's store wins over a clashing software write
  always_ff @(posedge clk_sys_in) begin
    if (store_rx) begin
      data_buffer_bytes_r[idx_r] <= rx_word;
    end else if (buf_wr) begin
      data_buffer_bytes_r[buf_sel] <= avs_writedata_in[7:0];
    end
  end

  // ***********************************************
  // Service and status flags
  // ***********************************************
  // Set wins over clear on every flag below
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      svc_r    <= 1'b0;
      unread_r <= 1'b0;
      irq_r    <= 1'b0;
    end else begin
      svc_r    <= svc_evt | (svc_r & ~(start_go | (word_end & last_word)));
      unread_r <= (irq_evt & mode_rx) | (unread_r & ~buf_rd & ~start_go);
      irq_r    <= irq_evt;
    end
  end

  assign serial_burst_interrupt_out = irq_r;

  // ***********************************************
  // Transfer sequencer
  // ***********************************************
  // Abort overrides everything; a stop lets the current word finish
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r      <= ST_IDLE;
      idx_r     <= 3'h0;
      bit_cnt_r <= 3'h0;
      fell_r    <= 1'b0;
      sck_r     <= 1'b1;
      so_r      <= 1'b1;
      tx_sh_r   <= 8'h00;
      rx_sh_r   <= 8'h00;
      gap_cnt_r <= 7'h00;
      dummy_r   <= 1'b0;
    end else if (ctl_r.abort) begin
      st_r    <= ST_IDLE;
      sck_r   <= 1'b1;
      dummy_r <= 1'b0;
    end else begin
      if (!ext_clk && shifting && tick) begin
        sck_r <= ~sck_r;
      end
      case (st_r)
        ST_IDLE: begin
          if (start_go) begin
            st_r      <= ST_SHIFT;
            idx_r     <= 3'h0;
            bit_cnt_r <= 3'h0;
            fell_r    <= 1'b0;
            sck_r     <= 1'b1;
            tx_sh_r   <= data_buffer_bytes_r[0];
            dummy_r   <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (sh_fall) begin
            so_r    <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            fell_r  <= 1'b1;
          end
          if (sh_rise) begin
            rx_sh_r   <= rx_next;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            fell_r    <= 1'b0;
          end
          if (word_end) begin
            idx_r     <= idx_nxt;
            bit_cnt_r <= 3'h0;
            dummy_r   <= ext_clk & mode_tx & ~mode_rx & last_word & ctl_r.start;
            if (end_now) begin
              st_r <= ST_IDLE;
            end else if (go_wait) begin
              st_r <= ST_WAIT;
            end else if (go_gap) begin
              st_r      <= ST_GAP;
              gap_cnt_r <= gap_len;
            end else begin
              tx_sh_r <= data_buffer_bytes_r[idx_nxt];
            end
          end
        end
        ST_GAP: begin
          if (!ctl_r.start) begin
            st_r <= ST_IDLE;
          end else if (tick) begin
            gap_cnt_r <= gap_cnt_r - 7'h01;
            if (gap_cnt_r == 7'h01) begin
              // Service was judged at the word end, so a gap always resumes shifting
              st_r    <= ST_SHIFT;
              tx_sh_r <= data_buffer_bytes_r[idx_r];
            end
          end
        end
        ST_WAIT: begin
          if (!ctl_r.start) begin
            st_r <= ST_IDLE;
          end else if (svc_done) begin
            st_r    <= ST_SHIFT;
            tx_sh_r <= data_buffer_bytes_r[idx_r];
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drive: internal clock only while a transfer is active
  assign shift_clk_out    = sck_r;
  assign shift_clk_oe_out = ~ext_clk & active;
  assign ser_data_out     = so_r;

  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_abort_stops_xfer: assert property (
    (wr_go && hit_c1 && avs_writedata_in[6]) |-> ##2 (st_r == ST_IDLE))
    else $error("abort did not stop transfer");
  a_abort_self_clear: assert property (
    (ctl_r.abort && !(wr_go && hit_c1)) |=> !ctl_r.abort)
    else $error("abort bit stuck");
  a_status_readback: assert property (
    (acc && !ack_r && hit_st) |=> (avs_readdata_out[7:6] == $past({active, shifting})))
    else $error("status byte wrong");
  a_clk_start_high: assert property (
    (start_go && !ext_clk && !ctl_r.abort) |=> (shift_clk_out && shift_clk_oe_out))
    else $error("shift clock not high at start");
  a_wait_stalls_clk: assert property (
    (st_r == ST_WAIT) |-> (shift_clk_out &&
      ($stable(shift_clk_out) || ($past(st_r) != ST_WAIT))))
    else $error("shift clock moved during wait");
  a_out_on_fall: assert property (
    $changed(ser_data_out) |-> $past(sh_fall))
    else $error("serial output changed off a falling edge");
  a_irq_after_last: assert property (
    serial_burst_interrupt_out |-> $past(word_end && last_word))
    else $error("interrupt without final word");
  a_word_ascend: assert property (
    (word_end && !last_word && !ctl_r.abort) |=> (idx_r == 3'($past(idx_r) + 3'h1)))
    else $error("buffer index did not advance");
  a_nibble_zero: assert property (
    (store_rx && four && !ctl_r.abort) |=> (data_buffer_bytes_r[$past(idx_r)][7:4] == 4'h0))
    else $error("upper nibble not zero");

  c_burst_irq: cover property (irq_r && mode_tx && !mode_rx);
  c_rx_irq:    cover property (irq_r && mode_rx && !mode_tx);
  c_auto_wait: cover property ((st_r == ST_WAIT) ##1 (st_r == ST_SHIFT));
  c_frame_gap: cover property ((st_r == ST_GAP) && (wctl_r.wait_code == 2'h3));
  c_abort_run: cover property (shifting && ctl_r.abort);

endmodule : csbp_top

// file: src/csbp_pkg.sv
/*
  Shared constants and types for the clocked serial buffered port.
  Assumes a word-addressed Avalon-MM slave with 32-bit data.
*/
package csbp_pkg;

  // ***********************************************
  // Register map (word index, byte address = 4*index)
  // ***********************************************
  localparam int          ADDR_W           = 13;
  localparam logic [12:0] IDX_PRIMARY_CTRL = 13'h1f95;
  localparam logic [12:0] IDX_WORD_CTRL    = 13'h1f96;
  localparam logic [12:0] IDX_STATUS       = 13'h1f97;
  localparam logic [12:0] IDX_BUF_BASE     = 13'h1f98;
  localparam int          BUF_WORDS        = 8;
  localparam int          STAT_ACTIVE_BIT  = 7;
  localparam int          STAT_SHIFT_BIT   = 6;

  // ***********************************************
  // Field encodings
  // ***********************************************
  localparam logic [2:0] MODE_TX8    = 3'h0;
  localparam logic [2:0] MODE_TX4    = 3'h2;
  localparam logic [2:0] MODE_TXRX8  = 3'h4;
  localparam logic [2:0] MODE_RX8    = 3'h5;
  localparam logic [2:0] MODE_RX4    = 3'h6;
  localparam logic [2:0] CLK_INT_MAX = 3'h5;
  localparam logic [2:0] CLK_EXT     = 3'h7;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] WCTL_RST    = 8'h00;

  // Half-period exponents of the internal shift clock, in system cycles
  localparam logic [3:0] HALF_EXP_0  = 4'hc;
  localparam logic [3:0] HALF_EXP_1  = 4'h7;
  localparam logic [3:0] HALF_EXP_2  = 4'h6;
  localparam logic [3:0] HALF_EXP_3  = 4'h5;
  localparam logic [3:0] HALF_EXP_4  = 4'h4;
  localparam logic [3:0] HALF_EXP_5  = 4'h3;
  localparam int         DIV_CNT_W   = 12;

  // ***********************************************
  // Types
  // ***********************************************
  typedef struct packed {
    logic       start;
    logic       abort;
    logic [2:0] mode;
    logic [2:0] clksel;
  } csbp_ctrl_s;

  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] wait_code;
    logic [2:0] count;
  } csbp_wctl_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP   = 2'b11,
    ST_WAIT  = 2'b10
  } csbp_state_e;

endpackage : csbp_pkg

// file: src/csbp_div.sv
/*
  Shift clock divider: one-cycle tick per half period of the selected rate.
  Assumes run_in drops between frames so each frame starts on a full half.
*/
`timescale 1ns/10ps
module csbp_div #(
  parameter int CNT_W = csbp_pkg::DIV_CNT_W
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);
  import csbp_pkg::*;

  // Counter must cover the slowest half period
  if (CNT_W < 12) begin : g_chk
    $error("csbp_div: CNT_W too small for slowest rate");
  end

  logic [CNT_W-1:0] cnt_r;
  wire  [3:0]       half_exp;
  wire  [CNT_W-1:0] mask;

  // Select decode, held as wires
  assign half_exp = (sel_in == 3'h0) ? HALF_EXP_0 :
                    (sel_in == 3'h1) ? HALF_EXP_1 :
                    (sel_in == 3'h2) ? HALF_EXP_2 :
                    (sel_in == 3'h3) ? HALF_EXP_3 :
                    (sel_in == 3'h4) ? HALF_EXP_4 : HALF_EXP_5;
  assign mask     = CNT_W'((32'h1 << half_exp) - 32'h1);
  assign tick_out = run_in & ((cnt_r & mask) == mask);

  // Restart from zero when idle so the first half is never short
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !run_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : csbp_div

// file: sim/csbp_peer.sv
/*
  Behavioural model of the external peripheral on the serial lines.
  Assumes the bench resolves the clock pin level and calls pulses() only
  while a transfer is active, since the pin clock must stand still between frames.
*/
`timescale 1ns/10ps
module csbp_peer (
  input  wire logic       sck_in,
  input  wire logic       so_in,
  input  wire logic       listen_in,
  input  wire logic [3:0] bits_in,
  output logic            si_out,
  output logic            ext_clk_out
);
  logic [7:0] rx_sr;
  logic [7:0] tx_sr;
  logic [7:0] got;
  logic [7:0] send_q[$];
  int         rx_n;
  int         tx_n;
  event       word_ev;

  initial begin
    si_out = 1'b1;
    ext_clk_out = 1'b1;
    rx_n = 0;
    tx_n = 0;
  end

  // Sample on the rising edge, first bit is the LSB
  always @(posedge sck_in) begin
    if (listen_in) begin
      rx_sr = {so_in, rx_sr[7:1]};
      rx_n++;
      if (rx_n == int'(bits_in)) begin
        got = rx_sr >> (8 - bits_in);
        rx_n = 0;
        ->word_ev;
      end
    end
  end

  // Drive on the falling edge; with nothing to send the line flips so stale bits show
  always @(negedge sck_in) begin
    if (tx_n == 0 && send_q.size() != 0) begin
      tx_sr = send_q.pop_front();
      tx_n = int'(bits_in);
    end
    if (tx_n != 0) begin
      si_out = tx_sr[0];
      tx_sr = tx_sr >> 1;
      tx_n--;
    end else begin
      si_out = ~si_out;
    end
  end

  // Pin clock bursts, 400 ns period, idle high
  task pulses(input int n);
    repeat (n) begin
      #200 ext_clk_out = 1'b0;
      #200 ext_clk_out = 1'b1;
    end
  endtask : pulses

  task clear();
    rx_n = 0;
    tx_n = 0;
    send_q.delete();
  endtask : clear
endmodule : csbp_peer

// file: sim/csbp_top_tb.sv
/*
  Self-checking bench for the clocked serial buffered port.
  Assumes an Avalon-MM slave with waitrequest and the peer model.
*/
`timescale 1ns/10ps
module csbp_top_tb;
  import csbp_pkg::*;
  typedef struct {logic [7:0] v; logic [7:0] m;} csbp_exp_s;

  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [12:0] avs_address_in = '0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        shift_clk_out;
  logic        shift_clk_oe_out;
  logic        ser_data_in;
  logic        ser_data_out;
  logic        irq;
  logic        peer_clk;
  logic        listen = 1'b0;
  logic [3:0]  bits = 4'h8;
  wire         sck_pin = shift_clk_oe_out ? shift_clk_out : peer_clk;
  csbp_exp_s   exp_rd[$];
  logic [7:0]  exp_ser[$];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          irq_cnt = 0;
  int          cyc = 0;
  integer      seed = 12;

  always #25 clk_sys_in = ~clk_sys_in;

  csbp_top i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_byteenable_in(4'h1),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .shift_clk_in(sck_pin),
    .shift_clk_out(shift_clk_out), .shift_clk_oe_out(shift_clk_oe_out),
    .ser_data_in(ser_data_in), .ser_data_out(ser_data_out),
    .serial_burst_interrupt_out(irq));

  csbp_peer i_peer (.sck_in(sck_pin), .so_in(ser_data_out), .listen_in(listen),
    .bits_in(bits), .si_out(ser_data_in), .ext_clk_out(peer_clk));

  // ***********************************************
  // Checking and closing
  // ***********************************************
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : check

  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Read results are compared at the edge where the master takes them
  always @(posedge clk_sys_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
      csbp_exp_s e;
      e = exp_rd.pop_front();
      check("readdata", e.v & e.m, avs_readdata_out[7:0] & e.m);
    end
    if (irq === 1'b1) irq_cnt++;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("Error run time expected end seen hang");
      report_and_stop();
    end
  end

  // Each word seen by the peer takes the oldest expected word; extras show as x
  always @(i_peer.word_ev) begin
    check("serial word", exp_ser.size() != 0 ? exp_ser.pop_front() : 8'hxx, i_peer.got);
  end

  // ***********************************************
  // Bus tasks
  // ***********************************************
  // Request held until waitrequest is sampled low at a rising edge, released at that edge
  task automatic bus(input logic wr, input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    avs_writedata_in <= {24'h0, d};
    @(posedge clk_sys_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic rd(input logic [12:0] a, input logic [7:0] v, input logic [7:0] m);
    exp_rd.push_back('{v, m});
    bus(1'b0, a, 8'h00);
  endtask : rd

  // ***********************************************
  // One burst: set up, run, service, abort
  // ***********************************************
  task automatic run(input logic [2:0] md, input logic [2:0] ck, input logic [2:0] cnt);
    logic [7:0] w [8];
    logic [7:0] r [8];
    logic       tx;
    logic       rx;
    logic [7:0] nm;
    logic [1:0] wt;
    int         k;
    int         base;
    tx = (md == MODE_TX8 || md == MODE_TX4 || md == MODE_TXRX8);
    rx = (md == MODE_RX8 || md == MODE_RX4 || md == MODE_TXRX8);
    nm = (md == MODE_TX4 || md == MODE_RX4) ? 8'h0f : 8'hff;
    // Frame wait only in internal-clock transmit/receive, longest setting
    wt = (md == MODE_TXRX8 && ck != CLK_EXT) ? 2'h3 : 2'h0;
    bits = (nm == 8'h0f) ? 4'h4 : 4'h8;
    listen = tx;
    i_peer.clear();
    bus(1'b1, IDX_PRIMARY_CTRL, {2'b01, md, ck});
    bus(1'b1, IDX_WORD_CTRL, {3'h0, wt, cnt});
    for (k = 0; k <= int'(cnt); k++) begin
      w[k] = 8'($random(seed));
      r[k] = 8'($random(seed));
      if (tx) bus(1'b1, IDX_BUF_BASE + 13'(k), w[k]);
      if (tx) exp_ser.push_back(w[k] & nm);
      if (rx) i_peer.send_q.push_back(r[k]);
    end
    base = irq_cnt;
    bus(1'b1, IDX_PRIMARY_CTRL, {2'b10, md, ck});
    repeat (2) @(negedge clk_sys_in);
    if (ck != CLK_EXT) check("clock pin", 8'h03, {6'h0, shift_clk_oe_out, shift_clk_out});
    rd(IDX_STATUS, 8'hc0, 8'hc0);
    if (ck == CLK_EXT) i_peer.pulses(int'(bits) * (int'(cnt) + 1));
    while (irq_cnt == base) @(posedge clk_sys_in);
    repeat (4) @(posedge clk_sys_in);
    check("burst interrupts", 8'h01, 8'(irq_cnt - base));
    if (ck != CLK_EXT) begin
      k = 0;
      repeat (40) @(negedge clk_sys_in) if (shift_clk_out !== 1'b1) k++;
      check("held clock", 8'h00, 8'(k));
      rd(IDX_STATUS, 8'h80, 8'hc0);
    end
    if (rx) for (k = 0; k <= int'(cnt); k++) rd(IDX_BUF_BASE + 13'(k), r[k] & nm, 8'hff);
    if (tx && ck != CLK_EXT) begin
      bus(1'b1, IDX_BUF_BASE + 13'h7, 8'h5a);
      k = 0;
      while (shift_clk_out !== 1'b0 && k < 100) begin
        @(negedge clk_sys_in);
        k++;
      end
      check("clock resumes", 8'h01, {7'h0, k < 100});
    end
    bus(1'b1, IDX_PRIMARY_CTRL, {2'b01, md, ck});
    rd(IDX_STATUS, 8'h00, 8'hc0);
    @(negedge clk_sys_in);
    check("clock enable", 8'h00, {7'h0, shift_clk_oe_out});
    $display("test done mode %h clock %h words %0d", md, ck, cnt + 1);
  endtask : run

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(IDX_PRIMARY_CTRL, 8'h00, 8'hff);
    rd(IDX_STATUS, 8'h00, 8'hc0);
    rd(13'h0000, 8'h00, 8'hff);
    $display("test done reset values");
    run(MODE_TX8, 3'h5, 3'h1);
    run(MODE_TX4, 3'h4, 3'h0);
    run(MODE_RX4, 3'h3, 3'h1);
    run(MODE_RX8, CLK_EXT, 3'h0);
    run(MODE_TXRX8, 3'h5, 3'h1);
    run(MODE_TX8, CLK_EXT, 3'h0);
    report_and_stop();
  end
endmodule : csbp_top_tb
